//--- common/i2cm_pkg.sv
// Overview of operation
// - Manual mode: data line pulled low when manual data bit is 0, else released.
// - Manual mode: clock line pulled low when manual clock bit is 0, else released.
// - Control bit 22 selects manual mode; lines follow manual bits, not the engine.
// - Control bit 25 reads back the sampled clock line level.
// - Divisor field 21:12, reset 0x142, sets a quarter bus period in clocks.
// - Field 11:8 counts bytes received in the run; one means byte one valid.
// - Field 7:4 shows the index of the step being executed.
// - Error bit 3 sets on write NACK when checked; clears a clock after start.
// - Any error makes the engine place a stop condition and end the run.
// - Busy bit 2 is 1 while running, set the clock after start is seen.
// - Skip-acknowledge bit 1 disables NACK detection on written bytes.
// - Start bit 0 begins the list; clearing it mid-run aborts with a stop.
// - Address bit 28 set: first quarter of each bit slot, clock low, takes its length from field 27:16.
// - Fields 13:11 and 10:8 set clock and data deglitch strength, 0 off.
// - Address field 7:0 holds shifted target address; hardware supplies bit 0.
// - Sixteen 4-bit steps run in order, low list register first, from bit 0.
// - Code 0 ends the list quietly, code 1 sends start, code 6 sends stop.
// - Code 2 sends address with write direction, code 3 with read direction.
// - Code 4 moves one byte in the last address direction; code 5 reads last.
// - Written bytes come in order from the two send registers, lowest first.
// - Received bytes are stored in order into the two receive registers.
// - Control bits 29:28 are the upper two bits of the quarter divisor.
// - Control bit 26 reads back the sampled data line level.
package i2cm_pkg;
  // ----------------------------------------------------------------
  // Register indices (word address)
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_CTRL = 16'h2140;
  localparam logic [15:0] REG_TADDR = 16'h2141;
  localparam logic [15:0] REG_LIST_LO = 16'h2142;
  localparam logic [15:0] REG_LIST_HI = 16'h2143;
  localparam logic [15:0] REG_SEND_LO = 16'h2144;
  localparam logic [15:0] REG_SEND_HI = 16'h2145;
  localparam logic [15:0] REG_RECV_LO = 16'h2146;
  localparam logic [15:0] REG_RECV_HI = 16'h2147;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int C_START = 0;
  localparam int C_ACKIGN = 1;
  localparam int C_DIV_LSB = 12;
  localparam int C_MANUAL = 22;
  localparam int C_MSCL = 23;
  localparam int C_MSDA = 24;
  localparam int C_EXT_LSB = 28;
  localparam int C_JIC = 31;
  localparam logic [9:0] DIV_RESET = 10'h142;
  localparam int A_SDAF_LSB = 8;
  localparam int A_SCLF_LSB = 11;
  localparam int A_LOWT_LSB = 16;
  localparam int A_LOWEN = 28;
  localparam logic [3:0] RX_FULL = 4'h8;
  // ----------------------------------------------------------------
  // Step codes and state types
  // ----------------------------------------------------------------
  localparam logic [3:0] TOK_END = 4'h0;
  localparam logic [3:0] TOK_START = 4'h1;
  localparam logic [3:0] TOK_ADDR_W = 4'h2;
  localparam logic [3:0] TOK_ADDR_R = 4'h3;
  localparam logic [3:0] TOK_DATA = 4'h4;
  localparam logic [3:0] TOK_LAST = 4'h5;
  localparam logic [3:0] TOK_STOP = 4'h6;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00, ENG_FETCH = 2'b01, ENG_RUN = 2'b10, ENG_HALT = 2'b11
  } i2cm_eng_t;
  typedef enum logic [1:0] {
    SL_START = 2'b00, SL_BIT = 2'b01, SL_STOP = 2'b10
  } i2cm_slot_t;
endpackage

//--- hdl/i2cm_engine.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_engine
  import i2cm_pkg::*;
#(
  parameter int FILT_SHIFT = 2
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [15:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic sclIn, // Clock line level
  output logic sclOut, // Clock line drive value, always 0
  output logic sclOeN, // Clock line enable, low pulls line low
  input wire logic sdaIn, // Data line level
  output logic sdaOut, // Data line drive value, always 0
  output logic sdaOeN // Data line enable, low pulls line low
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, taddr_reg, listLo_reg, listHi_reg;
  logic [31:0] sendLo_reg, sendHi_reg;
  logic [7:0] rxMem [8];
  logic [1:0] syncA, syncB, filt;
  logic [5:0] fcnt [2];
  i2cm_eng_t state_reg;
  i2cm_slot_t slot_reg;
  logic [1:0] quarter_reg;
  logic [11:0] qCnt_reg;
  logic [3:0] bitIdx_reg, tokIdx_reg, rCount_reg;
  logic [2:0] wIdx_reg;
  logic [7:0] shift_reg;
  logic readDir_reg, byteRead_reg, nackLast_reg, isAddr_reg;
  logic err_reg, busy_reg, ending_reg;
  logic engScl_reg, engSda_reg, engScl_next, engSda_next;
  logic [3:0] tok;
  logic [11:0] qLen, lowLen;
  logic bitVal, startOn;

  assign startOn = ctrl_reg[C_START];
  // Divisor field extended by upper bits
  assign qLen = {ctrl_reg[C_EXT_LSB +: 2], ctrl_reg[C_DIV_LSB +: 10]};
  assign lowLen = taddr_reg[A_LOWT_LSB +: 12];
  // Step picked by index, low list first
  assign tok = tokIdx_reg[3] ? listHi_reg[{tokIdx_reg[2:0], 2'b00} +: 4]
                             : listLo_reg[{tokIdx_reg[2:0], 2'b00} +: 4];

  // Reload value for the quarter counter; a zero length still costs one cycle
  function automatic logic [11:0] reloadOf(input logic [11:0] len);
    reloadOf = (len == 12'h000) ? 12'h000 : len - 12'h001;
  endfunction

  // First quarter of a bit slot may be stretched by the custom low time
  function automatic logic [11:0] firstLen(input i2cm_slot_t s,
                                           input logic [31:0] ta,
                                           input logic [11:0] q);
    if (s == SL_BIT && ta[A_LOWEN]) begin
      firstLen = reloadOf(ta[A_LOWT_LSB +: 12]);
    end else begin
      firstLen = reloadOf(q);
    end
  endfunction

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control, address and list storage; status bits are not stored here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= {10'h000, DIV_RESET, 12'h000};
      taddr_reg <= 32'h0000_0000;
      listLo_reg <= 32'h0000_0000;
      listHi_reg <= 32'h0000_0000;
      sendLo_reg <= 32'h0000_0000;
      sendHi_reg <= 32'h0000_0000;
    end else if (ce && wr) begin
      case (addr)
        // Start and abort bit, with steering bits
        REG_CTRL: ctrl_reg <= wdata & 32'hB1FF_F003;
        REG_TADDR: taddr_reg <= wdata & 32'h1FFF_3FFF;
        REG_LIST_LO: listLo_reg <= wdata;
        REG_LIST_HI: listHi_reg <= wdata;
        REG_SEND_LO: sendLo_reg <= wdata;
        REG_SEND_HI: sendHi_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped indices read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (ce && rd) begin
      case (addr)
        REG_CTRL: rdata <= {ctrl_reg[C_JIC], 1'b0, ctrl_reg[29:28], 1'b0,
                            filt[1], filt[0], ctrl_reg[24:12], rCount_reg,
                            tokIdx_reg, err_reg, busy_reg, ctrl_reg[1:0]};
        REG_TADDR: rdata <= taddr_reg;
        REG_LIST_LO: rdata <= listLo_reg;
        REG_LIST_HI: rdata <= listHi_reg;
        REG_SEND_LO: rdata <= sendLo_reg;
        REG_SEND_HI: rdata <= sendHi_reg;
        REG_RECV_LO: rdata <= {rxMem[3], rxMem[2], rxMem[1], rxMem[0]};
        REG_RECV_HI: rdata <= {rxMem[7], rxMem[6], rxMem[5], rxMem[4]};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers and deglitch filters
  // ----------------------------------------------------------------
  // Index 0 is the clock line, index 1 the data line. A change must hold
  // for level times four cycles before it is believed; slow edges cost
  // that much extra latency on every sample.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 2'b11;
      syncB <= 2'b11;
      filt <= 2'b11;
      fcnt[0] <= 6'h00;
      fcnt[1] <= 6'h00;
    end else if (ce) begin
      syncA <= {sdaIn, sclIn};
      syncB <= syncA;
      for (int i = 0; i < 2; i++) begin
        if (syncB[i] == filt[i]) begin
          fcnt[i] <= 6'h00;
        end else if (fcnt[i] >= (6'(i == 0 ? taddr_reg[A_SCLF_LSB +: 3]
                                    : taddr_reg[A_SDAF_LSB +: 3])
                                 << FILT_SHIFT)) begin
          filt[i] <= syncB[i];
          fcnt[i] <= 6'h00;
        end else begin
          fcnt[i] <= fcnt[i] + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus levels per quarter
  // ----------------------------------------------------------------
  // Value sent in the current bit; release while reading, and on the
  // ninth bit release for a written byte, answer for a read byte
  always_comb begin
    if (bitIdx_reg != 4'h8) begin
      bitVal = byteRead_reg ? 1'b1 : shift_reg[7];
    end else begin
      // ACK data reads, NACK the last read
      bitVal = byteRead_reg ? nackLast_reg : 1'b1;
    end
  end

  // Four quarters; data moves only while clock low, except the start and stop edges
  always_comb begin
    engScl_next = 1'b1;
    engSda_next = 1'b1;
    case (slot_reg)
      SL_START: begin
        // Start: data falls while clock high
        engScl_next = (quarter_reg == 2'd1) || (quarter_reg == 2'd2);
        engSda_next = (quarter_reg == 2'd0) || (quarter_reg == 2'd1);
      end
      SL_BIT: begin
        engScl_next = (quarter_reg == 2'd1) || (quarter_reg == 2'd2);
        // Hold data while the clock falls; the shift lands at that edge
        engSda_next = (quarter_reg == 2'd3) ? engSda_reg : bitVal;
      end
      SL_STOP: begin
        // Stop: data rises while clock high
        engScl_next = (quarter_reg != 2'd0);
        engSda_next = quarter_reg[1];
      end
      default: begin
        engScl_next = 1'b1;
        engSda_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Step list engine
  // ----------------------------------------------------------------
  // Aborts and errors are honoured at slot boundaries only, so a stop
  // never cuts a clock high phase short.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ENG_IDLE;
      slot_reg <= SL_STOP;
      quarter_reg <= 2'd3;
      qCnt_reg <= 12'h000;
      bitIdx_reg <= 4'h0;
      tokIdx_reg <= 4'h0;
      rCount_reg <= 4'h0;
      wIdx_reg <= 3'd0;
      shift_reg <= 8'h00;
      readDir_reg <= 1'b0;
      byteRead_reg <= 1'b0;
      nackLast_reg <= 1'b0;
      isAddr_reg <= 1'b0;
      err_reg <= 1'b0;
      busy_reg <= 1'b0;
      ending_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rxMem[i] <= 8'h00;
      end
    end else if (ce) begin
      // Software may also write the receive words directly
      if (wr && addr == REG_RECV_LO) begin
        for (int i = 0; i < 4; i++) begin
          rxMem[i] <= wdata[8*i +: 8];
        end
      end
      if (wr && addr == REG_RECV_HI) begin
        for (int i = 0; i < 4; i++) begin
          rxMem[i+4] <= wdata[8*i +: 8];
        end
      end
      case (state_reg)
        ENG_IDLE: begin
          if (startOn) begin
            busy_reg <= 1'b1;
            err_reg <= 1'b0;
            tokIdx_reg <= 4'h0;
            rCount_reg <= 4'h0;
            wIdx_reg <= 3'd0;
            ending_reg <= 1'b0;
            state_reg <= ENG_FETCH;
          end
        end
        ENG_FETCH: begin
          quarter_reg <= 2'd0;
          bitIdx_reg <= 4'h0;
          state_reg <= ENG_RUN;
          if (!startOn) begin
            ending_reg <= 1'b1;
            slot_reg <= SL_STOP;
            qCnt_reg <= firstLen(SL_STOP, taddr_reg, qLen);
          end else begin
            case (tok)
              TOK_START: begin
                slot_reg <= SL_START;
                qCnt_reg <= firstLen(SL_START, taddr_reg, qLen);
              end
              TOK_ADDR_W, TOK_ADDR_R: begin
                shift_reg <= {taddr_reg[7:1], tok[0]};
                readDir_reg <= tok[0];
                byteRead_reg <= 1'b0;
                isAddr_reg <= 1'b1;
                slot_reg <= SL_BIT;
                qCnt_reg <= firstLen(SL_BIT, taddr_reg, qLen);
              end
              TOK_DATA, TOK_LAST: begin
                byteRead_reg <= readDir_reg || (tok == TOK_LAST);
                nackLast_reg <= (tok == TOK_LAST);
                isAddr_reg <= 1'b0;
                shift_reg <= wIdx_reg[2]
                  ? sendHi_reg[{wIdx_reg[1:0], 3'b000} +: 8]
                  : sendLo_reg[{wIdx_reg[1:0], 3'b000} +: 8];
                slot_reg <= SL_BIT;
                qCnt_reg <= firstLen(SL_BIT, taddr_reg, qLen);
              end
              TOK_STOP: begin
                slot_reg <= SL_STOP;
                qCnt_reg <= firstLen(SL_STOP, taddr_reg, qLen);
              end
              default: begin
                state_reg <= ENG_HALT;
                busy_reg <= 1'b0;
              end
            endcase
          end
        end
        ENG_RUN: begin
          if (qCnt_reg != 12'h000) begin
            qCnt_reg <= qCnt_reg - 12'h001;
          end else if (quarter_reg != 2'd3) begin
            if (quarter_reg == 2'd2 && slot_reg == SL_BIT) begin
              // Sample at end of clock high
              if (bitIdx_reg != 4'h8) begin
                shift_reg <= {shift_reg[6:0], filt[1]};
              end else if (!byteRead_reg && filt[1] && !ctrl_reg[C_ACKIGN]) begin
                err_reg <= 1'b1;
              end
            end
            quarter_reg <= quarter_reg + 2'd1;
            qCnt_reg <= reloadOf(qLen);
          end else begin
            // End of slot
            quarter_reg <= 2'd0;
            if (slot_reg == SL_STOP && (ending_reg || err_reg)) begin
              state_reg <= ENG_HALT;
              busy_reg <= 1'b0;
            end else if (err_reg || !startOn) begin
              // Error or abort ends with stop
              ending_reg <= 1'b1;
              slot_reg <= SL_STOP;
              qCnt_reg <= firstLen(SL_STOP, taddr_reg, qLen);
            end else if (slot_reg == SL_BIT && bitIdx_reg != 4'h8) begin
              bitIdx_reg <= bitIdx_reg + 4'h1;
              qCnt_reg <= firstLen(SL_BIT, taddr_reg, qLen);
            end else begin
              if (slot_reg == SL_BIT && byteRead_reg) begin
                if (rCount_reg != RX_FULL) begin
                  rxMem[rCount_reg[2:0]] <= shift_reg;
                  rCount_reg <= rCount_reg + 4'h1;
                end
              end else if (slot_reg == SL_BIT && !isAddr_reg) begin
                wIdx_reg <= wIdx_reg + 3'd1;
              end
              if (tokIdx_reg == 4'hF) begin
                state_reg <= ENG_HALT;
                busy_reg <= 1'b0;
              end else begin
                tokIdx_reg <= tokIdx_reg + 4'h1;
                state_reg <= ENG_FETCH;
              end
            end
          end
        end
        ENG_HALT: begin
          // Wait for start low before rearming
          if (!startOn) begin
            state_reg <= ENG_IDLE;
          end
        end
        default: state_reg <= ENG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // Engine levels only move while a slot runs; idle holds the last level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      engScl_reg <= 1'b1;
      engSda_reg <= 1'b1;
    end else if (ce && state_reg == ENG_RUN) begin
      engScl_reg <= engScl_next;
      engSda_reg <= engSda_next;
    end
  end

  // Open drain: enable low pulls low, high releases the line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclOeN <= 1'b1;
      sdaOeN <= 1'b1;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else if (ce) begin
      if (ctrl_reg[C_MANUAL]) begin
        sclOeN <= ctrl_reg[C_MSCL];
        sdaOeN <= ctrl_reg[C_MSDA];
      end else begin
        sclOeN <= engScl_reg;
        sdaOeN <= engSda_reg;
      end
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- bench/i2cm_engine_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_engine_asserts
  import i2cm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic [15:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic sclIn, // Clock line level
  input wire logic sclOut, // Clock drive value
  input wire logic sclOeN, // Clock enable, low pulls
  input wire logic sdaIn, // Data line level
  input wire logic sdaOut, // Data drive value
  input wire logic sdaOeN // Data enable, low pulls
);
  // -------------------------------------------------------------
  // Shadows and checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [31:0] ctlReg;
  logic [31:0] taReg;
  // Copies of what software wrote, to judge read-back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctlReg <= 32'h00142000;
      taReg <= 32'h00000000;
    end else if (wr && ce && addr == REG_CTRL) begin
      ctlReg <= wdata;
    end else if (wr && ce && addr == REG_TADDR) begin
      taReg <= wdata;
    end
  end
  a_drive_low: assert property (!sclOut && !sdaOut)
    else $error("drive value not low");
  a_manual_scl: assert property ((ctlReg[C_MANUAL] && !wr)[*4] |->
    sclOeN == ctlReg[C_MSCL]) else $error("manual clock wrong");
  a_manual_sda: assert property ((ctlReg[C_MANUAL] && !wr)[*4] |->
    sdaOeN == ctlReg[C_MSDA]) else $error("manual data wrong");
  // Unmapped reads return zero
  a_unmapped_zero: assert property (rd && (addr < REG_CTRL ||
    addr > REG_RECV_HI) |=> rdata == 32'h0) else $error("unmapped not 0");
  // Read data held between reads
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved");
  a_addr_readback: assert property (rd && addr == REG_TADDR |=>
    rdata == (taReg & 32'h1FFF3FFF)) else $error("addr reg readback");
  a_ctrl_readback: assert property (rd && addr == REG_CTRL |=>
    (rdata & 32'hB1FFF003) == (ctlReg & 32'hB1FFF003))
    else $error("ctrl readback");
  a_edges_apart: assert property (!ctlReg[C_MANUAL] &&
    $changed(sclOeN) |-> $stable(sdaOeN)) else $error("lines moved together");
  // two quarters high, bench quarter is 4
  a_scl_high: assert property (!ctlReg[C_MANUAL] && $rose(sclOeN) |->
    sclOeN[*8]) else $error("clock high too short");
  c_run_start: cover property (wr && addr == REG_CTRL && wdata[C_START]);
  c_bus_start: cover property (sclOeN && $fell(sdaOeN));
  c_recv_read: cover property (rd && addr == REG_RECV_LO);
endmodule
bind i2cm_engine i2cm_engine_asserts i_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sclIn(sclIn),
  .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOeN(sdaOeN));
`default_nettype wire

//--- bench/i2cm_target.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_target (
  input wire logic scl, // Clock line level
  input wire logic sda, // Data line level
  input wire logic nackWr, // Refuse written data bytes
  output logic sdaOeN // Low pulls data line low
);
  logic [7:0] sh, adr, tx, mAck;
  logic [7:0] got [0:15];
  logic act, first, rdDir;
  int bitN, nGot, nTx, nStop;
  // Released and quiet until a start is seen
  initial begin
    sdaOeN = 1'b1;
    act = 1'b0;
    mAck = 8'h00;
    tx = 8'hA0;
    nGot = 0;
    nTx = 0;
    nStop = 0;
  end
  // Start and stop: data edge with clock high
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    // The clock fall that ends the start is not a bit
    bitN = -1;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    nStop++;
  end
  always @(posedge scl) if (act) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    else if (rdDir && !first) mAck = {mAck[6:0], sda};
  end
  // Answers and read bits change only with the clock low
  always @(negedge scl) if (act) begin
    bitN++;
    if (bitN == 8 && first) begin
      adr = sh;
      rdDir = sh[0];
      sdaOeN = 1'b0;
    end else if (bitN == 8 && !rdDir) begin
      got[nGot[3:0]] = sh;
      nGot++;
      sdaOeN = nackWr;
    end else if (bitN == 9) begin
      bitN = 0;
      if (rdDir && !first) nTx++;
      tx = 8'hA0 + nTx[7:0];
      // Stop sending once the master refuses a byte
      sdaOeN = (rdDir && (first || !mAck[0])) ? tx[7] : 1'b1;
      first = 1'b0;
    end else if (rdDir && !first && bitN < 8) begin
      sdaOeN = tx[7 - bitN];
    end else begin
      sdaOeN = 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- bench/i2cm_engine_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_engine_tb_top
  import i2cm_pkg::*;
;
  localparam logic [31:0] CQ = 32'h00004000;
  logic clk, rstn, wr, rd, nackWr, sclOeN, sdaOeN, tgtOeN, sclOut, sdaOut;
  logic ce;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, rv;
  wire scl;
  wire sda;
  int n_errors, n_compared, s;
  int cyc = 0;
  // Pull-ups: a line is low only while someone pulls it
  assign scl = sclOeN;
  assign sda = sdaOeN & tgtOeN;
  i2cm_engine i_dut (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sclIn(scl),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN));
  i2cm_target i_tgt (.scl(scl), .sda(sda), .nackWr(nackWr), .sdaOeN(tgtOeN));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, runs need well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("MISMATCH timeout expected 0 seen 1");
      complete_run();
    end
  end
  task automatic chk(input string w, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  // One-cycle strobes, a spare edge after each
  task automatic wrReg(input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input string w, input logic [15:0] a,
    input logic [31:0] m, e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    rv = rdata;
    chk(w, e, rv & m);
  endtask
  // Load a list, restart, wait for idle
  task automatic run(input logic [31:0] lst, c);
    wrReg(REG_LIST_LO, lst);
    wrReg(REG_CTRL, c);
    wrReg(REG_CTRL, c | 32'h1);
    rc("busy", REG_CTRL, 32'h4, 32'h4);
    for (int i = 0; i < 1000 && rv[2] !== 1'b0; i++) begin
      rc("poll", REG_CTRL, 32'h0, 32'h0);
    end
    rc("idle", REG_CTRL, 32'h4, 32'h0);
  endtask
  initial begin
    {rstn, wr, rd, nackWr} = 4'h0;
    addr = 16'h0000;
    wdata = 32'h00000000;
    ce = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    rc("ctrl reset", REG_CTRL, 32'hFFFFFFFF, 32'h06142000);
    rc("addr reset", REG_TADDR, 32'hFFFFFFFF, 32'h0);
    rc("unmapped", 16'h2148, 32'hFFFFFFFF, 32'h0);
    wrReg(REG_TADDR, 32'h00000050);
    wrReg(REG_SEND_LO, 32'h44332211);
    run(32'h00064421, CQ);
    chk("waddr", 32'h50, {24'h0, i_tgt.adr});
    chk("wbytes", 32'h2211, {16'h0, i_tgt.got[1], i_tgt.got[0]});
    rc("no error", REG_CTRL, 32'h8, 32'h0);
    run(32'h00065431, CQ);
    chk("raddr", 32'h51, {24'h0, i_tgt.adr});
    rc("recv", REG_RECV_LO, 32'hFFFFFFFF, 32'h0000A1A0);
    rc("count", REG_CTRL, 32'hF00, 32'h200);
    chk("acks", 32'h1, {30'h0, i_tgt.mAck[1:0]});
    nackWr <= 1'b1;
    s = i_tgt.nStop;
    run(32'h00064421, CQ);
    rc("nack", REG_CTRL, 32'hFC, 32'h28);
    chk("nack stop", 32'(s + 1), 32'(i_tgt.nStop));
    run(32'h00064421, CQ | 32'h2);
    rc("skip", REG_CTRL, 32'h8, 32'h0);
    chk("skip bytes", 32'h5, 32'(i_tgt.nGot));
    nackWr <= 1'b0;
    s = i_tgt.nStop;
    wrReg(REG_LIST_LO, 32'h06444421);
    wrReg(REG_CTRL, CQ);
    wrReg(REG_CTRL, CQ | 32'h1);
    repeat (200) @(posedge clk);
    wrReg(REG_CTRL, CQ);
    repeat (100) @(posedge clk);
    rc("abort", REG_CTRL, 32'h4, 32'h0);
    chk("abort stop", 32'(s + 1), 32'(i_tgt.nStop));
    // Custom low time and light filtering on both lines
    wrReg(REG_TADDR, 32'h10100952);
    run(32'h00064421, CQ);
    rc("low time", REG_CTRL, 32'h8, 32'h0);
    chk("low addr", 32'h52, {24'h0, i_tgt.adr});
    // Writes are ignored while the clock enable is low
    ce <= 1'b0;
    wrReg(REG_TADDR, 32'h00000050);
    ce <= 1'b1;
    rc("ce freeze", REG_TADDR, 32'hFFFFFFFF, 32'h10100952);
    wrReg(REG_CTRL, CQ | 32'h01400000);
    repeat (8) @(posedge clk);
    chk("scl pin", 32'h0, {31'h0, sclOeN});
    rc("scl level", REG_CTRL, 32'h06000000, 32'h04000000);
    wrReg(REG_CTRL, CQ | 32'h00C00000);
    repeat (8) @(posedge clk);
    chk("sda pin", 32'h0, {31'h0, sdaOeN});
    rc("sda level", REG_CTRL, 32'h06000000, 32'h02000000);
    complete_run();
  end
endmodule
`default_nettype wire
